// >>> hw/tap_supervisor_pkg.sv
/*
  constants, types and timing figures for the tap changer supervisor.
  assumes a single 100 mhz clock domain and synchronous binary inputs.
*/
package tap_supervisor_pkg;

  localparam int num_inputs = 8;
  localparam int func_width = 6;
  localparam logic [5:0] func_busy = 6'h07;
  localparam logic [5:0] func_err_level = 6'h0e;
  localparam logic [5:0] func_err_pulse = 6'h29;

  // tap position field
  localparam int tap_width = 8;
  localparam logic [7:0] tap_reset = 8'h00;

  // one millisecond tick from the 100 mhz clock
  localparam int clk_period_ns = 10;
  localparam int tick_ns = 1000000;
  localparam int tick_cycles = tick_ns / clk_period_ns;
  localparam int ms_width = 20;
  localparam int guard_extra_s = 2;
  localparam int guard_extra_ms = guard_extra_s * 1000;
  localparam int pulse_ms = 100;

  // supervisor states, one-hot encoded
  typedef enum logic [4:0] {
    st_idle = 5'b00001,
    st_busy = 5'b00010,
    st_error = 5'b00100,
    st_guard = 5'b01000,
    st_unused = 5'b10000
  } sup_state_type;

endpackage

// >>> hw/ms_ticker.sv
/*
  millisecond tick generator.
  assumes the 100 mhz system clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module ms_ticker
  import tap_supervisor_pkg::*;
#(
  parameter int tick_len = tick_cycles
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // tick
  output logic tick_q
);

  logic [31:0] cnt_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else if (cnt_q == 32'(tick_len - 1)) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick_q <= 1'b0;
    end
  end

endmodule // ms_ticker

// >>> hw/tap_changer_supervisor.sv
/*
  tap changer supervisor: tap position decode, busy supervision,
  changer error level and pulse, command guard time.
  assumes inputs synchronous to clk and settings held steady by software.
*/
`timescale 1ns/1ps
module tap_changer_supervisor
  import tap_supervisor_pkg::*;
#(
  parameter int tick_len = tick_cycles
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // binary inputs and their assigned functions
  input wire logic [7:0] bin_in,
  input wire logic [47:0] bin_func,
  // position inputs
  input wire logic digit_weight_one,
  input wire logic digit_weight_two,
  input wire logic digit_weight_four,
  input wire logic digit_weight_eight,
  input wire logic digit_weight_ten,
  input wire logic digit_weight_twenty,
  input wire logic digit_weight_forty,
  input wire logic tap_sign_negative,
  input wire logic binary_weight_sixteen,
  input wire logic binary_weight_thirtytwo,
  // settings
  input wire logic tap_ind_enable,
  input wire logic binary_mode,
  input wire logic paired,
  input wire logic [19:0] max_op_ms,
  // companion unit
  input wire logic companion_busy,
  input wire logic companion_error,
  // tap command handshake
  input wire logic tap_cmd_req,
  output logic tap_cmd_grant_q,
  output logic cmd_blocked_q,
  // tap display
  output logic [7:0] tap_pos_q,
  output logic tap_valid_q,
  output logic tap_dashes_q,
  // status
  output logic [7:0] input_active_q,
  output logic changer_busy_q,
  // relay outputs by function
  output logic [7:0] relay_out_q
);

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [7:0] decode_tap(
    input logic bin_mode,
    input logic [9:0] w
  );
    logic [7:0] sum;
    sum = 8'h00;
    sum = {7'h0, w[0]} + {6'h0, w[1], 1'b0} + {5'h0, w[2], 2'b0}
        + {4'h0, w[3], 3'b0};
    if (bin_mode)
      sum = sum + {3'h0, w[8], 4'h0} + {2'h0, w[9], 5'h0};
    else begin
      sum = sum + (w[4] ? 8'h0a : 8'h00) + (w[5] ? 8'h14 : 8'h00)
          + (w[6] ? 8'h28 : 8'h00);
      if (w[7])
        sum = 8'(-sum);
    end
    return sum;
  endfunction

  logic tick;
  ms_ticker #(.tick_len(tick_len)) u_tick (
    .clk(clk),
    .nrst(nrst),
    .tick_q(tick)
  );

  // -------------------------------------------------------------
  // input reporting and busy decode
  // -------------------------------------------------------------
  logic local_busy;
  logic busy_wired;
  always_comb begin
    local_busy = 1'b0;
    busy_wired = 1'b0;
    for (int i = 0; i < num_inputs; i++) begin
      if (bin_func[i*func_width +: func_width] == func_busy) begin
        busy_wired = 1'b1;
        local_busy = local_busy | bin_in[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      input_active_q <= 8'h00;
    else
      input_active_q <= bin_in;
  end

  // -------------------------------------------------------------
  // tap position
  // -------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tap_pos_q <= tap_reset;
      tap_valid_q <= 1'b0;
      tap_dashes_q <= 1'b1;
    end else if (tap_ind_enable) begin
      tap_pos_q <= decode_tap(binary_mode, {binary_weight_thirtytwo,
        binary_weight_sixteen, tap_sign_negative, digit_weight_forty,
        digit_weight_twenty, digit_weight_ten, digit_weight_eight,
        digit_weight_four, digit_weight_two, digit_weight_one});
      tap_valid_q <= 1'b1;
      tap_dashes_q <= 1'b0;
    end else begin
      tap_pos_q <= tap_reset;
      tap_valid_q <= 1'b0;
      tap_dashes_q <= 1'b1;
    end
  end

  // -------------------------------------------------------------
  // busy supervision
  // -------------------------------------------------------------
  logic [19:0] busy_ms_q;
  logic local_err_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_ms_q <= 20'h0;
      local_err_q <= 1'b0;
    end else if (!busy_wired || !local_busy) begin
      busy_ms_q <= 20'h0;
      local_err_q <= 1'b0;
    end else begin
      if (tick && busy_ms_q != 20'hfffff)
        busy_ms_q <= busy_ms_q + 20'h1;
      if (busy_ms_q > max_op_ms)
        local_err_q <= 1'b1;
    end
  end

  logic err_now;
  assign err_now = local_err_q | (paired & companion_error);

  always_ff @(posedge clk) begin
    if (!nrst)
      changer_busy_q <= 1'b0;
    else
      changer_busy_q <= (busy_wired & local_busy) | (paired & companion_busy);
  end

  // -------------------------------------------------------------
  // error pulse, one per event
  // -------------------------------------------------------------
  logic armed_q;
  logic pulse_q;
  logic [19:0] pulse_ms_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      armed_q <= 1'b1;
      pulse_q <= 1'b0;
      pulse_ms_q <= 20'h0;
    end else if (err_now && armed_q) begin
      armed_q <= 1'b0;
      pulse_q <= 1'b1;
      pulse_ms_q <= 20'h0;
    end else begin
      if (!err_now)
        armed_q <= 1'b1;
      if (pulse_q && tick) begin
        pulse_ms_q <= pulse_ms_q + 20'h1;
        if (pulse_ms_q == 20'(pulse_ms - 1))
          pulse_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      relay_out_q <= 8'h00;
    else
      for (int i = 0; i < num_inputs; i++) begin
        if (bin_func[i*func_width +: func_width] == func_err_level)
          relay_out_q[i] <= err_now;
        else if (bin_func[i*func_width +: func_width] == func_err_pulse)
          relay_out_q[i] <= pulse_q;
        else
          relay_out_q[i] <= 1'b0;
      end
  end

  // -------------------------------------------------------------
  // command guard when no busy input exists
  // -------------------------------------------------------------
  sup_state_type state_q;
  logic [19:0] guard_ms_q;
  logic [20:0] guard_limit;
  logic no_busy_source;
  assign guard_limit = {1'b0, max_op_ms} + 21'(guard_extra_ms);
  assign no_busy_source = !busy_wired && !paired;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= st_idle;
      guard_ms_q <= 20'h0;
      tap_cmd_grant_q <= 1'b0;
      cmd_blocked_q <= 1'b0;
    end else begin
      tap_cmd_grant_q <= 1'b0;
      case (state_q)
        st_idle: begin
          cmd_blocked_q <= 1'b0;
          if (tap_cmd_req) begin
            tap_cmd_grant_q <= 1'b1;
            guard_ms_q <= 20'h0;
            if (no_busy_source) begin
              state_q <= st_guard;
              cmd_blocked_q <= 1'b1;
            end
          end
        end
        st_guard: begin
          if (tick)
            guard_ms_q <= guard_ms_q + 20'h1;
          // ticks are not phase aligned to the grant, so wait one past
          // the limit to never release early
          if ({1'b0, guard_ms_q} > guard_limit) begin
            state_q <= st_idle;
            cmd_blocked_q <= 1'b0;
          end
        end
        default: begin
          state_q <= st_idle;
          cmd_blocked_q <= 1'b0;
        end
      endcase
    end
  end

endmodule // tap_changer_supervisor

// >>> testbench/tap_changer_supervisor_assertions.sv
/* port checker of the supervisor; assumes a bind to its top. */
`timescale 1ns/1ps
module tcs_checker (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // watched ports
  input wire logic [7:0] bin_in,
  input wire logic [47:0] bin_func,
  input wire logic tap_ind_enable,
  input wire logic paired,
  input wire logic companion_busy,
  input wire logic companion_error,
  input wire logic tap_cmd_req,
  input wire logic tap_cmd_grant_q,
  input wire logic cmd_blocked_q,
  input wire logic tap_valid_q,
  input wire logic tap_dashes_q,
  input wire logic [7:0] input_active_q,
  input wire logic changer_busy_q,
  input wire logic [7:0] relay_out_q
);
  // ----
  // checks
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence held_s;
    cmd_blocked_q ##1 cmd_blocked_q;
  endsequence
  dash_reset_a: assert property (
    $rose(nrst) |-> tap_dashes_q && !tap_valid_q) else $error("no dashes");
  dash_off_a: assert property (
    !tap_ind_enable |=> tap_dashes_q && !tap_valid_q) else $error("shown");
  valid_on_a: assert property (
    tap_ind_enable |=> tap_valid_q && !tap_dashes_q) else $error("hidden");
  active_copy_a: assert property (
    nrst |=> input_active_q == $past(bin_in)) else $error("activity");
  grant_cause_a: assert property (
    tap_cmd_grant_q |-> $past(tap_cmd_req)) else $error("stray grant");
  block_start_a: assert property (
    $rose(cmd_blocked_q) |-> tap_cmd_grant_q) else $error("stray guard");
  block_hold_a: assert property (
    held_s |-> !tap_cmd_grant_q) else $error("grant in guard");
  comp_busy_a: assert property (
    paired && companion_busy |-> ##[1:2] changer_busy_q) else $error("cbusy");
  comp_err_a: assert property (
    paired && companion_error && bin_func[11:6] == 6'h0e
    |-> ##[1:2] relay_out_q[1]) else $error("companion error");
  local_busy_a: assert property (
    bin_func[5:0] == 6'h07 && bin_in[0] |-> ##[1:2] changer_busy_q)
    else $error("local busy");
endmodule // tcs_checker

// >>> testbench/tap_drive_model.sv
/* tap changer drive: in-operation contact after each command;
   assumes one-cycle command pulses. */
`timescale 1ns/1ps
module tap_drive_model #(
  parameter int op_len = 8
) (
  // clock
  input wire logic clk,
  // command and fault
  input wire logic cmd,
  input wire logic stuck,
  // contact
  output logic busy
);
  int cnt = 0;
  // ----
  // drive
  // ----
  // shorter than max
  always @(posedge clk) begin
    if (cmd) cnt <= op_len;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  // stuck stands for a jammed drive
  assign busy = stuck || cnt > 0;
endmodule // tap_drive_model

// >>> testbench/tb_tap_changer_supervisor.sv
/* bench of the supervisor; assumes one ms is four cycles. */
`timescale 1ns/1ps
module tb_tap_changer_supervisor;
  logic clk, nrst, stuck, busy;
  logic [9:0] pos;
  logic [6:0] bin_hi;
  logic [47:0] bin_func;
  logic digit_weight_one, digit_weight_two, digit_weight_four;
  logic digit_weight_eight, digit_weight_ten, digit_weight_twenty;
  logic digit_weight_forty, tap_sign_negative;
  logic binary_weight_sixteen, binary_weight_thirtytwo;
  logic tap_ind_enable, binary_mode, paired, tap_cmd_req;
  logic companion_busy, companion_error, tap_cmd_grant_q;
  logic cmd_blocked_q, tap_valid_q, tap_dashes_q, changer_busy_q;
  logic [19:0] max_op_ms;
  logic [7:0] tap_pos_q, input_active_q, relay_out_q;
  wire logic [7:0] bin_in = {bin_hi, busy};
  int fail_count = 0;
  int tests_run = 0;
  assign {binary_weight_thirtytwo, binary_weight_sixteen, tap_sign_negative,
    digit_weight_forty, digit_weight_twenty, digit_weight_ten,
    digit_weight_eight, digit_weight_four, digit_weight_two,
    digit_weight_one} = pos;
  tap_changer_supervisor #(.tick_len(4)) i_dut (.*);
  tap_drive_model #(.op_len(8)) i_drive (
    .clk(clk), .cmd(tap_cmd_grant_q), .stuck(stuck), .busy(busy));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----
  // helpers
  // ----
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return relay_out_q[1];
      1: return relay_out_q[2];
      2: return cmd_blocked_q;
      default: return tap_cmd_grant_q;
    endcase
  endfunction
  task automatic await(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (sig(k) !== v) begin
      cyc(1);
      n++;
      if (n > lim) begin
        chk({7'h00, sig(k)}, {7'h00, v});
        close_out();
      end
    end
  endtask
  task automatic setpos(input logic [9:0] v);
    @(posedge clk);
    pos <= v;
    cyc(2);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_display();
    chk(tap_dashes_q, 8'h01);
    chk(tap_valid_q, 8'h00);
    @(posedge clk);
    tap_ind_enable <= 1'b1;
    setpos(10'h0c5);
    chk(tap_pos_q, 8'hd3);
    chk(tap_valid_q, 8'h01);
    setpos(10'h03a);
    chk(tap_pos_q, 8'h28);
    @(posedge clk);
    binary_mode <= 1'b1;
    setpos(10'h349);
    chk(tap_pos_q, 8'h39);
    @(posedge clk);
    tap_ind_enable <= 1'b0;
    bin_hi <= 7'h55;
    cyc(2);
    chk(tap_dashes_q, 8'h01);
    chk(tap_pos_q, 8'h00);
    chk(input_active_q, 8'haa);
  endtask
  task automatic t_busy();
    @(posedge clk);
    bin_func <= {30'h0, 6'h29, 6'h0e, 6'h07};
    tap_cmd_req <= 1'b1;
    await(3, 1, 4);
    @(posedge clk);
    tap_cmd_req <= 1'b0;
    cyc(4);
    chk(changer_busy_q, 8'h01);
    chk(cmd_blocked_q, 8'h00);
    cyc(30);
    chk(relay_out_q, 8'h00);
    @(posedge clk);
    stuck <= 1'b1;
    cyc(10);
    chk(relay_out_q, 8'h00);
    await(0, 1, 30);
    await(1, 1, 2);
    chk(relay_out_q, 8'h06);
    cyc(380);
    chk(relay_out_q, 8'h06);
    await(1, 0, 30);
    cyc(450);
    chk(relay_out_q, 8'h02);
    @(posedge clk);
    stuck <= 1'b0;
    await(0, 0, 10);
    chk(relay_out_q, 8'h00);
  endtask
  task automatic t_guard();
    int g;
    g = 0;
    @(posedge clk);
    bin_func <= {30'h0, 6'h29, 6'h0e, 6'h00};
    max_op_ms <= 20'h00002;
    stuck <= 1'b1;
    tap_cmd_req <= 1'b1;
    await(3, 1, 4);
    chk(cmd_blocked_q, 8'h01);
    chk(changer_busy_q, 8'h00);
    repeat (7990) begin
      cyc(1);
      if (tap_cmd_grant_q !== 1'b0) g++;
    end
    chk(g[7:0], 8'h00);
    chk(relay_out_q, 8'h00);
    await(2, 0, 60);
    await(3, 1, 4);
    @(posedge clk);
    tap_cmd_req <= 1'b0;
    stuck <= 1'b0;
  endtask
  task automatic t_paired();
    @(posedge clk);
    paired <= 1'b1;
    {companion_busy, companion_error} <= 2'h3;
    cyc(3);
    chk(changer_busy_q, 8'h01);
    chk(relay_out_q[1], 8'h01);
    @(posedge clk);
    {companion_busy, companion_error} <= 2'h0;
    await(0, 0, 10);
    @(posedge clk);
    bin_func <= {30'h0, 6'h29, 6'h0e, 6'h07};
    max_op_ms <= 20'h00003;
    stuck <= 1'b1;
    cyc(3);
    chk(changer_busy_q, 8'h01);
    await(0, 1, 40);
  endtask
  initial begin
    {nrst, stuck, tap_ind_enable, binary_mode} = 4'h0;
    {paired, tap_cmd_req, companion_busy, companion_error} = 4'h0;
    pos = 10'h000;
    bin_hi = 7'h00;
    bin_func = 48'h0;
    max_op_ms = 20'h00003;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    cyc(1);
    t_display();
    t_busy();
    t_guard();
    t_paired();
    close_out();
  end
endmodule // tb_tap_changer_supervisor
bind tap_changer_supervisor tcs_checker i_chk (.*);
